// ===== pkg/nvram_pkg.sv
package nvram_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 8;               // Byte address width of the register window
  localparam int AXI_DATA_W = 32;              // Data width of the register bus

  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;   // Instruction register
  localparam logic [7:0] OFS_STATUS = 8'h04;   // Status, sticky bits write-one-to-clear
  localparam logic [7:0] OFS_RAMWR  = 8'h08;   // RAM write request, address and data

  // Status bit positions
  localparam int SB_RECALL_DONE = 0;           // Recall-done latch
  localparam int SB_WEL         = 1;           // Write-enable latch
  localparam int SB_STORE_BUSY  = 2;           // Store running
  localparam int SB_RECALL_BUSY = 3;           // Recall running
  localparam int SB_INHIBIT     = 4;           // Power-up inhibit running
  localparam int SB_LOW_SUPPLY  = 5;           // Low-supply indication, synchronised
  localparam int SB_WR_REFUSED  = 6;           // Sticky: a RAM write was refused
  localparam int SB_ST_DROPPED  = 7;           // Sticky: a store request was discarded

  // Instruction layout: start bit, four ignored address bits, three-bit op field
  localparam int CMD_START_BIT = 7;            // Start bit position
  localparam logic [2:0] OP_WRITE_ENABLE_CLEAR = 3'h0;  // write_enable_clear_cmd
  localparam logic [2:0] OP_STORE              = 3'h1;  // store_cmd
  localparam logic [2:0] OP_WRITE_ENABLE_SET   = 3'h4;  // write_enable_set_cmd
  localparam logic [2:0] OP_RECALL             = 3'h5;  // recall_cmd

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;   // Mapped register
  localparam logic [1:0] RESP_SLVERR = 2'h2;   // Unmapped offset

  // Timing
  localparam int CLK_PERIOD_NS           = 10;          // ref_clk period
  localparam int POWERUP_INHIBIT_TIME_NS = 200;         // Least inhibit after power is stable
  localparam int INHIBIT_CYC = (POWERUP_INHIBIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INHIBIT_W   = 5;                        // Width of the inhibit counter
  localparam int RECALL_TIME_NS    = 1500;               // Typical recall duration
  localparam int RECALL_CYC  = (RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_TIME_MAX_NS = 10000000;           // Longest store duration
  localparam int STORE_CYC   = STORE_TIME_MAX_NS / CLK_PERIOD_NS;
  localparam int TIMER_W     = 20;                       // Busy timer width, holds STORE_CYC

  // Control sequencer states
  typedef enum logic [1:0] {
    ST_INHIBIT = 2'b00,
    ST_IDLE    = 2'b01,
    ST_RECALL  = 2'b10,
    ST_STORE   = 2'b11
  } seq_state_t;

endpackage

// ===== verilog/pin_sync.sv
module pin_sync #(
  parameter logic RST_VAL = 1'b1                // Level assumed while in reset
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pinIn,                      // Asynchronous pin level
  output logic      level                       // Filtered, synchronous level
);

  logic s1_r;                                   // First stage, read only by s2_r
  logic s2_r;                                   // Second stage
  logic s3_r;                                   // Third stage
  logic level_r;                                // Accepted level

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_r    <= RST_VAL;
      s2_r    <= RST_VAL;
      s3_r    <= RST_VAL;
      level_r <= RST_VAL;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign level = level_r;

endmodule // pin_sync

// ===== verilog/busy_timer.sv
module busy_timer #(
  parameter int W = 20                          // Counter width
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         start,              // Load the count, one-cycle pulse
  input  wire logic [W-1:0] loadVal,            // Busy duration in cycles, at least one
  input  wire logic         abort,              // Drop the count without a done pulse
  output logic              busy,               // Counting
  output logic              done                // Last busy cycle
);

  logic [W-1:0] cnt_r;                          // Remaining busy cycles

  // Start has priority, so a back-to-back operation reloads cleanly
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= loadVal;
    end else if (abort) begin
      cnt_r <= '0;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign busy = (cnt_r != '0);
  assign done = (cnt_r == W'(1)) && !abort;

endmodule // busy_timer

// ===== verilog/nvram_store_recall_control.sv
// Operation
// - Recall instruction or low recall pin copies array
// - No RAM write or store before recall
// - Finished recall sets recall-done latch
// - Automatic recall after power-up
// - Ignore everything during power-up inhibit
// - Store instruction or low store pin requests store
// - Store needs recall-done, write-enable and request
// - Running store blocks all other functions
// - Finished store clears write-enable latch
// - Low supply aborts store, clears write-enable
// - Op codes: store, recall, enable set, clear
// - Write-enable clear at power-up, needed first
// - Write-enable holds until clear, store, power
module nvram_store_recall_control
  import nvram_pkg::*;
#(
  parameter int STORE_DUR  = STORE_CYC,         // Store busy cycles
  parameter int RECALL_DUR = RECALL_CYC         // Recall busy cycles
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  storePinN,     // Store pin, active low
  input  wire logic                  recallPinN,    // Recall pin, active low
  input  wire logic                  lowSupplyIn,   // Supply monitor, high when supply is low
  output logic                       recallActive,  // EEPROM to RAM copy running
  output logic                       storeActive,   // RAM to EEPROM copy running
  output logic                       ramWrStrobe,   // One-cycle RAM write grant
  output logic [3:0]                 ramWrAddr,     // RAM word address
  output logic [15:0]                ramWrData      // RAM word data
);

  // Bus slave state
  logic                  awReady_r;             // Write address may be taken
  logic                  wReady_r;              // Write data may be taken
  logic                  awHeld_r;              // Write address captured
  logic                  wHeld_r;               // Write data captured
  logic [AXI_ADDR_W-1:0] awAddr_r;              // Captured write address
  logic [AXI_DATA_W-1:0] wData_r;               // Captured write data
  logic [3:0]            wStrb_r;               // Captured byte enables
  logic                  bValid_r;              // Write response pending
  logic [1:0]            bResp_r;               // Write response code
  logic                  arReady_r;             // Read address may be taken
  logic                  rValid_r;              // Read data pending
  logic [AXI_DATA_W-1:0] rData_r;               // Read data
  logic [1:0]            rResp_r;               // Read response code

  // Control state
  seq_state_t            state_r;               // Sequencer state
  seq_state_t            state_nxt;             // Sequencer next state
  logic [INHIBIT_W-1:0]  inhibitCnt_r;          // Cycles spent in power-up inhibit
  logic                  recallDone_r;          // Recall-done latch
  logic                  wel_r;                 // Write-enable latch
  logic                  wrRefused_r;           // Sticky refused RAM write
  logic                  stDropped_r;           // Sticky discarded store
  logic [7:0]            cmdLast_r;             // Last instruction byte written
  logic                  storeLvlPrev_r;        // Store pin level one cycle ago
  logic                  recallLvlPrev_r;       // Recall pin level one cycle ago
  logic                  recallActive_r;        // Output flop
  logic                  storeActive_r;         // Output flop
  logic                  ramWrStrobe_r;         // Output flop
  logic [3:0]            ramWrAddr_r;           // Output flop
  logic [15:0]           ramWrData_r;           // Output flop

  // Synchronised pins and timer
  logic storeLvl;                               // Store pin level, synchronous
  logic recallLvl;                              // Recall pin level, synchronous
  logic lowSupply;                              // Low-supply level, synchronous
  logic tmrBusy;                                // Timer counting
  logic tmrDone;                                // Last cycle of the timed operation

  // Pins from outside the clock domain pass four flops each
  pin_sync #(.RST_VAL(1'b1)) u_store_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (storePinN),
    .level   (storeLvl)
  );
  pin_sync #(.RST_VAL(1'b1)) u_recall_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (recallPinN),
    .level   (recallLvl)
  );
  // Reset value low so that the inhibit interval is not mistaken for a brown-out
  pin_sync #(.RST_VAL(1'b0)) u_supply_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (lowSupplyIn),
    .level   (lowSupply)
  );

  // Register decode
  wire [5:0] wrIdx    = awAddr_r[7:2];
  wire [5:0] rdIdx    = s_axi_araddr[7:2];
  wire       doWrite  = awHeld_r && wHeld_r && !bValid_r;
  wire       wrCmdHit = (wrIdx == OFS_CMD[7:2]);
  wire       wrStHit  = (wrIdx == OFS_STATUS[7:2]);
  wire       wrRamHit = (wrIdx == OFS_RAMWR[7:2]);
  wire       wrMapped = wrCmdHit || wrStHit || wrRamHit;
  wire       rdMapped = (rdIdx == OFS_CMD[7:2]) || (rdIdx == OFS_STATUS[7:2])
                        || (rdIdx == OFS_RAMWR[7:2]);
  wire       arTake   = s_axi_arvalid && arReady_r;

  // Instruction decode; the address bits of the byte are ignored
  wire       cmdWr    = doWrite && wrCmdHit && wStrb_r[0];
  wire       cmdOk    = cmdWr && wData_r[CMD_START_BIT];
  wire [2:0] opField  = wData_r[2:0];
  wire       inIdle   = (state_r == ST_IDLE);
  wire       inhibit  = (state_r == ST_INHIBIT);

  // Pins act on the change to low; a pin held low requests once
  wire storeFall  = storeLvlPrev_r && !storeLvl;
  wire recallFall = recallLvlPrev_r && !recallLvl;

  // Requests count only when idle: inhibit and running operations swallow them
  wire recallReq = inIdle
                   && ((cmdOk && opField == OP_RECALL) || recallFall);
  wire storeReq  = inIdle && !recallReq
                   && ((cmdOk && opField == OP_STORE) || storeFall);
  wire storeGo   = storeReq && recallDone_r && wel_r && !lowSupply;
  wire storeDrop = storeReq && !storeGo;
  wire wrenReq   = inIdle && cmdOk && (opField == OP_WRITE_ENABLE_SET);
  wire wrdsReq   = inIdle && cmdOk && (opField == OP_WRITE_ENABLE_CLEAR);
  wire autoStart = inhibit && (inhibitCnt_r == INHIBIT_W'(INHIBIT_CYC - 1));
  wire storeAbort  = (state_r == ST_STORE) && lowSupply;
  wire storeFinish = (state_r == ST_STORE) && tmrDone;
  wire recallFinish = (state_r == ST_RECALL) && tmrDone;

  // RAM writes need a completed recall and a set write-enable latch
  wire ramWrReq = doWrite && wrRamHit && (wStrb_r[2:0] == 3'h7);
  wire ramWrOk  = ramWrReq && inIdle && recallDone_r && wel_r && !lowSupply;
  wire ramWrBad = ramWrReq && !ramWrOk;
  wire clrSticky = doWrite && wrStHit && wStrb_r[0];

  wire                 tmrStart = autoStart || recallReq || storeGo;
  wire [TIMER_W-1:0]   tmrLoad  = storeGo ? TIMER_W'(STORE_DUR) : TIMER_W'(RECALL_DUR);

  // One timer serves both operations; they never overlap
  busy_timer #(.W(TIMER_W)) u_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (tmrStart),
    .loadVal (tmrLoad),
    .abort   (storeAbort),
    .busy    (tmrBusy),
    .done    (tmrDone)
  );

  // Status word built from named fields; unused bits read as zero
  logic [AXI_DATA_W-1:0] statusWord;
  always_comb begin
    statusWord                 = '0;
    statusWord[SB_RECALL_DONE] = recallDone_r;
    statusWord[SB_WEL]         = wel_r;
    statusWord[SB_STORE_BUSY]  = (state_r == ST_STORE);
    statusWord[SB_RECALL_BUSY] = (state_r == ST_RECALL);
    statusWord[SB_INHIBIT]     = inhibit;
    statusWord[SB_LOW_SUPPLY]  = lowSupply;
    statusWord[SB_WR_REFUSED]  = wrRefused_r;
    statusWord[SB_ST_DROPPED]  = stDropped_r;
  end

  wire [AXI_DATA_W-1:0] rdMux =
    (rdIdx == OFS_CMD[7:2])    ? {24'h000000, cmdLast_r} :
    (rdIdx == OFS_STATUS[7:2]) ? statusWord :
    (rdIdx == OFS_RAMWR[7:2])  ? {12'h000, ramWrAddr_r, ramWrData_r} : 32'h00000000;

  // Write channels: address and data taken in either order, response after both
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awReady_r <= 1'b1;
      wReady_r  <= 1'b1;
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awAddr_r  <= '0;
      wData_r   <= '0;
      wStrb_r   <= 4'h0;
      bValid_r  <= 1'b0;
      bResp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awReady_r) begin
        awAddr_r  <= s_axi_awaddr;
        awHeld_r  <= 1'b1;
        awReady_r <= 1'b0;
      end
      if (s_axi_wvalid && wReady_r) begin
        wData_r  <= s_axi_wdata;
        wStrb_r  <= s_axi_wstrb;
        wHeld_r  <= 1'b1;
        wReady_r <= 1'b0;
      end
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
      end
      // Ready returns only after the response, so one write is in flight
      if (bValid_r && s_axi_bready) begin
        bValid_r  <= 1'b0;
        awReady_r <= 1'b1;
        wReady_r  <= 1'b1;
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
      rData_r   <= '0;
      rResp_r   <= RESP_OKAY;
    end else if (arTake) begin
      arReady_r <= 1'b0;
      rValid_r  <= 1'b1;
      rData_r   <= rdMux;
      rResp_r   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r  <= 1'b0;
      arReady_r <= 1'b1;
    end
  end

  // Sequencer next state; a brown-out ends a store at once
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INHIBIT: begin
        if (autoStart) begin
          state_nxt = ST_RECALL;
        end
      end
      ST_IDLE: begin
        if (recallReq) begin
          state_nxt = ST_RECALL;
        end else if (storeGo) begin
          state_nxt = ST_STORE;
        end
      end
      ST_RECALL: begin
        if (tmrDone) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_STORE: begin
        if (storeAbort || tmrDone) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_INHIBIT;
      end
    endcase
  end

  // Sequencer and output flops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r        <= ST_INHIBIT;
      inhibitCnt_r   <= '0;
      recallActive_r <= 1'b0;
      storeActive_r  <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      recallActive_r <= (state_nxt == ST_RECALL);
      storeActive_r  <= (state_nxt == ST_STORE);
      if (inhibit) begin
        inhibitCnt_r <= inhibitCnt_r + INHIBIT_W'(1);
      end
    end
  end

  // Latches: clearing events beat the enable instruction for safety
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      recallDone_r <= 1'b0;
      wel_r        <= 1'b0;
    end else begin
      if (recallFinish) begin
        recallDone_r <= 1'b1;
      end
      if (lowSupply || wrdsReq || storeFinish) begin
        wel_r <= 1'b0;
      end else if (wrenReq) begin
        wel_r <= 1'b1;
      end
    end
  end

  // Sticky flags, instruction echo, pin history and RAM write port
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wrRefused_r     <= 1'b0;
      stDropped_r     <= 1'b0;
      cmdLast_r       <= 8'h00;
      storeLvlPrev_r  <= 1'b1;
      recallLvlPrev_r <= 1'b1;
      ramWrStrobe_r   <= 1'b0;
      ramWrAddr_r     <= 4'h0;
      ramWrData_r     <= 16'h0000;
    end else begin
      // Set wins over a clear in the same cycle
      wrRefused_r     <= ramWrBad || (wrRefused_r && !(clrSticky && wData_r[SB_WR_REFUSED]));
      stDropped_r     <= storeDrop || (stDropped_r && !(clrSticky && wData_r[SB_ST_DROPPED]));
      storeLvlPrev_r  <= storeLvl;
      recallLvlPrev_r <= recallLvl;
      ramWrStrobe_r   <= ramWrOk;
      if (cmdWr) begin
        cmdLast_r <= wData_r[7:0];
      end
      if (ramWrOk) begin
        ramWrAddr_r <= wData_r[19:16];
        ramWrData_r <= wData_r[15:0];
      end
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign recallActive  = recallActive_r;
  assign storeActive   = storeActive_r;
  assign ramWrStrobe   = ramWrStrobe_r;
  assign ramWrAddr     = ramWrAddr_r;
  assign ramWrData     = ramWrData_r;

  // Checks on the sequencer and latches
  localparam int A_INH = INHIBIT_CYC;
  localparam int A_RCL = RECALL_DUR;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_inhibit_len: assert property ((inhibit && inhibitCnt_r == '0)
    |-> !recallActive_r [*2] ##(A_INH - 1) recallActive_r)
    else $error("auto recall not started after inhibit");
  a_inhibit_quiet: assert property (inhibit
    |=> !storeActive_r && !ramWrStrobe_r && !wel_r)
    else $error("activity during power-up inhibit");
  a_recall_start: assert property (recallReq |=> recallActive_r)
    else $error("recall request not acted on");
  a_recall_len: assert property ($rose(recallActive_r)
    |-> ##(A_RCL - 1) recallActive_r ##1 !recallActive_r)
    else $error("recall busy length wrong");
  a_recall_latch: assert property (recallFinish |=> recallDone_r && inIdle)
    else $error("recall-done latch not set");
  a_store_gate: assert property ($rose(storeActive_r)
    |-> $past(recallDone_r) && $past(wel_r))
    else $error("store started without both latches");
  a_store_start: assert property (storeGo |=> storeActive_r)
    else $error("qualified store not started");
  a_store_blocks: assert property ((storeActive_r && !lowSupply && !tmrDone)
    |=> storeActive_r && !recallActive_r)
    else $error("store interrupted");
  a_store_clears: assert property (storeFinish |=> !wel_r && !storeActive_r)
    else $error("write-enable kept after store");
  a_low_supply: assert property (lowSupply |=> !wel_r && !storeActive_r)
    else $error("low supply did not stop store");
  a_write_enable_set_cmd_set: assert property ((wrenReq && !lowSupply) |=> wel_r)
    else $error("enable instruction ignored");
  a_wel_holds: assert property ((wel_r && !wrdsReq && !lowSupply && !storeFinish)
    |=> wel_r)
    else $error("write-enable lost without cause");
  a_ram_write: assert property (ramWrStrobe_r
    |-> $past(recallDone_r) && $past(wel_r))
    else $error("RAM write granted while locked");
  a_drop_keeps: assert property ((storeDrop && !wrenReq && !lowSupply)
    |=> $stable(wel_r) && $stable(recallDone_r) && !storeActive_r)
    else $error("discarded store changed state");

  c_auto_recall: cover property (recallFinish && !recallDone_r);
  c_store_done:  cover property (storeFinish);
  c_store_abort: cover property (storeAbort);
  c_store_drop:  cover property (storeDrop);

endmodule // nvram_store_recall_control

// ===== test/host_pins.sv
// Host strobes and supply monitor; pins idle high as if pulled up
module host_pins (
  input  wire logic ref_clk,
  output logic      storePinN,
  output logic      recallPinN,
  output logic      lowSupplyIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    storePinN = 1'b1;
    recallPinN = 1'b1;
    lowSupplyIn = 1'b0;
  end
  // Low pulse well past the synchroniser depth
  task pulse(input logic isStore);
    @(posedge ref_clk);
    if (isStore) storePinN <= 1'b0;
    else recallPinN <= 1'b0;
    repeat (8) @(posedge ref_clk);
    storePinN <= 1'b1;
    recallPinN <= 1'b1;
  endtask
  task supply(input logic v);
    @(posedge ref_clk);
    lowSupplyIn <= v;
  endtask
endmodule // host_pins

// ===== test/nvram_store_recall_control_test.sv
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin errorCnt++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module nvram_store_recall_control_test import nvram_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rstn = 0, awV = 0, wV = 0, bRdy = 0, arV = 0, rRdy = 0;
  logic [7:0] awA = 0, arA = 0;
  logic [3:0] wS = 4'hF;          // Byte enables, all lanes unless a scenario narrows them
  logic [31:0] wD = 0, rD;
  logic awR, wR, bV, arR, rV, recA, stoA, ramS, sP, rP, lS;
  logic [1:0] bResp, rResp;
  logic [3:0] ramA;
  logic [15:0] ramD, rnd;
  logic [33:0] rdQ[$];            // Expected {response, read data}
  logic [19:0] ramQ[$];           // Expected {address, data} of granted RAM writes
  logic [1:0] bQ[$];              // Expected write responses
  int errorCnt = 0, totalChecks = 0, seed = 48;
  always #5 ref_clk = ~ref_clk;
  // Mapped offsets answer OKAY, anything else SLVERR
  function automatic logic [1:0] respOf(input logic [7:0] a);
    return (a inside {OFS_CMD, OFS_STATUS, OFS_RAMWR}) ? RESP_OKAY : RESP_SLVERR;
  endfunction
  host_pins hp (.ref_clk(ref_clk), .storePinN(sP), .recallPinN(rP), .lowSupplyIn(lS));
  nvram_store_recall_control #(.STORE_DUR(50), .RECALL_DUR(10)) dut (.ref_clk(ref_clk),
    .rstn(rstn), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR),
    .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wR),
    .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA),
    .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rResp),
    .s_axi_rvalid(rV), .s_axi_rready(rRdy), .storePinN(sP), .recallPinN(rP),
    .lowSupplyIn(lS), .recallActive(recA), .storeActive(stoA), .ramWrStrobe(ramS),
    .ramWrAddr(ramA), .ramWrData(ramD));
  // Ready flags are looked at mid-cycle, acted on at the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    bQ.push_back(respOf(a));
    @(posedge ref_clk);
    awA <= a;
    wD <= d;
    awV <= 1;
    wV <= 1;
    bRdy <= 1;
    do begin
      @(negedge ref_clk);
      ka = awV & awR;
      kw = wV & wR;
      kb = bV;
      @(posedge ref_clk);
      if (ka) awV <= 0;
      if (kw) wV <= 0;
    end while (!kb);
    bRdy <= 0;
  endtask
  // Every register reads zero above bit 15 in the words that the scenarios read
  task rd(input logic [7:0] a, input logic [15:0] e);
    logic ka, kr;
    rdQ.push_back({respOf(a), 16'h0000, e});
    @(posedge ref_clk);
    arA <= a;
    arV <= 1;
    rRdy <= 1;
    do begin
      @(negedge ref_clk);
      ka = arV & arR;
      kr = rV;
      @(posedge ref_clk);
      if (ka) arV <= 0;
    end while (!kr);
    rRdy <= 0;
  endtask
  // Watcher: oldest note against each result as it appears
  always @(negedge ref_clk) begin
    if (rV && rRdy) `CHK({rResp, rD}, rdQ.pop_front())
    if (bV && bRdy) `CHK(bResp, bQ.pop_front())
    if (ramS) `CHK({ramA, ramD}, ramQ.pop_front())
  end
  task endOfTest;
    $display("checks=%0d errors=%0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: the scenarios need well under a thousand cycles
  initial begin
    #300000;
    errorCnt++;
    endOfTest();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    wr(OFS_RAMWR, 32'h00001234);
    wait (recA);
    wait (!recA);
    rd(OFS_STATUS, 16'h0041);
    wr(OFS_CMD, 32'h00000081);
    rd(OFS_STATUS, 16'h00C1);
    wr(OFS_CMD, 32'h00000084);
    // Enable clear without byte lane 0 must be ignored
    wS <= 4'hE;
    wr(OFS_CMD, 32'h00000080);
    wS <= 4'hF;
    rd(OFS_STATUS, 16'h00C3);
    rnd = 16'($random(seed));
    ramQ.push_back({4'h5, rnd});
    wr(OFS_RAMWR, {12'h000, 4'h5, rnd});
    hp.pulse(1'b1);
    wait (stoA);
    wr(OFS_CMD, 32'h00000085);
    rd(OFS_STATUS, 16'h00C7);
    wait (!stoA);
    rd(OFS_STATUS, 16'h00C1);
    hp.pulse(1'b0);
    wait (recA);
    wait (!recA);
    wr(OFS_CMD, 32'h00000085);
    wait (recA);
    wait (!recA);
    // Store by instruction, then a brown-out well before it can finish
    wr(OFS_CMD, 32'h00000084);
    wr(OFS_CMD, 32'h00000081);
    hp.supply(1'b1);
    repeat (8) @(posedge ref_clk);
    rd(OFS_STATUS, 16'h00E1);
    wr(OFS_STATUS, 32'h000000C0);
    rd(OFS_STATUS, 16'h0021);
    wr(8'h0C, 32'h00000084);
    rd(8'h0C, 16'h0000);
    repeat (4) @(posedge ref_clk);
    endOfTest();
  end
endmodule // nvram_store_recall_control_test
